/* File: rtl/cmfr_mailbox_filter.sv */
// Summary of operation
// - remote frames are handled only by mailboxes 0..3, never 4 and 5
// - remote requests are compared through masks from highest mailbox down
// - remote hit on auto-answer transmit mailbox sets its transmit request
// - remote hit on transmit mailbox without auto-answer is dropped
// - a remote hit on a transmit mailbox ends the search
// - remote hit on receive mailbox is stored like data, pending set
// - change-data withholds the selected mailbox but keeps its request
// - receive mailbox 2 or 3 with request sends remote frame, takes answer
// - sent remote frame clears request, sets no acknowledge
// - mailboxes 0,1 receive, 4,5 transmit, 2,3 by direction bit
// - identifier compare skips masked bits; mask off means exact match
// - mailboxes 2,3 use second mask pair, 0,1 the first
// - mailboxes 3 and 2 are checked before 1 and 0
// - extension select 0 accepts only the stored frame format
// - extension select 1 accepts both; standard uses bits 28..18 only
// - mask bit 0 must match, 1 is don't care; high 12..0, low 15..0
// - direction 0 transmit, 1 receive; all bits clear at reset
// - enable bit 1 enables mailbox and blocks identifier writes
// - disabled mailbox storage is plain cpu memory
// - data/control write to busy transmit mailbox is denied and flagged, unless change-data selects that mailbox
// - auto-answer bit is identifier high bit 13, mailboxes 2,3 only
module cmfr_mailbox_filter (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset_n,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [17:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// received frames from the protocol engine
	input  wire logic                      rxValid,
	input  wire cmfr_pkg::cmfr_frame_type  rxFrame,
	// transmit requests to the protocol engine
	output logic                           txReq,
	output logic      [2:0]                txMailbox,
	output cmfr_pkg::cmfr_frame_type       txFrame,
	input  wire logic                      txDone,
	input  wire logic                      txFail
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0] mem      [cmfr_pkg::NUM_MB][cmfr_pkg::MB_WORDS];
	logic [15:0] next_mem [cmfr_pkg::NUM_MB][cmfr_pkg::MB_WORDS];
	logic [15:0] mailboxDirectionEnable, next_mailboxDirectionEnable;
	logic [15:0] localMaskHigh [2];
	logic [15:0] next_localMaskHigh [2];
	logic [15:0] localMaskLow [2];
	logic [15:0] next_localMaskLow [2];
	logic [5:2]  transmitRequestFlag, next_transmitRequestFlag;
	logic [5:2]  transmitCancelFlag, next_transmitCancelFlag;
	logic [5:2]  transmitAcknowledgeFlag, next_transmitAcknowledgeFlag;
	logic [3:0]  receivePendingFlag, next_receivePendingFlag;
	logic        changeDataRequest, next_changeDataRequest;
	logic [1:0]  mailboxSelectField, next_mailboxSelectField;
	logic        writeDeniedFlag, next_writeDeniedFlag;
	logic [31:0] next_prdata;
	cmfr_pkg::cmfr_tx_state_type txState, next_txState;
	logic [2:0]  next_txMailbox;
	cmfr_pkg::cmfr_frame_type   next_txFrame;

	logic [5:0]  mailboxEnableBits;
	logic [3:2]  mailboxDirectionBits;
	logic [15:0] regIdx;
	logic [15:0] mbOff;
	logic        mbSpace;
	logic [2:0]  cpuMb;
	logic [2:0]  cpuWord;
	logic        apbWrite;
	logic        mapped;
	logic [3:0]  eligible;
	logic        hitFound;
	logic [1:0]  hitIdx;
	logic        hitTx;
	logic        storeEn;
	logic        denyData;
	logic        candFound;
	logic [2:0]  candIdx;

	assign mailboxEnableBits    = mailboxDirectionEnable[5:0];
	assign mailboxDirectionBits = mailboxDirectionEnable[7:6];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// receive direction: 0,1 always, 2,3 by bit, 4,5 never
	function automatic logic isRx(input logic [2:0] mb,
	                              input logic [3:2] dir);
		if (mb < 3'h2) begin
			return 1'b1;
		end
		if (mb < 3'h4) begin
			return dir[mb[1:0]];
		end
		return 1'b0;
	endfunction

	// masked identifier compare of one mailbox
	function automatic logic idMatch(input logic [15:0] idh,
	                                 input logic [15:0] idl,
	                                 input logic [15:0] mh,
	                                 input logic [15:0] ml,
	                                 input cmfr_pkg::cmfr_frame_type f);
		logic [28:0] mask;
		logic [28:0] cmp;
		mask = idh[cmfr_pkg::IDH_AME_BIT] ? {mh[12:0], ml} : 29'h0;
		// standard frames compare only the 11 upper bits
		cmp  = f.ide ? ~29'h0 : cmfr_pkg::STD_ID_BITS;
		if (!mh[cmfr_pkg::MASK_EXT_BIT] &&
		    idh[cmfr_pkg::IDH_IDE_BIT] != f.ide) begin
			return 1'b0;
		end
		return (((f.id ^ {idh[12:0], idl}) & ~mask & cmp) == 29'h0);
	endfunction

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	always_comb begin
		regIdx  = paddr[17:2];
		mbOff   = regIdx - cmfr_pkg::IDX_MB_BASE;
		cpuMb   = mbOff[5:3];
		cpuWord = mbOff[2:0];
		mbSpace = (regIdx >= cmfr_pkg::IDX_MB_BASE) && (mbOff < 16'h0030) &&
		          (cpuWord != 3'h7) && (paddr[1:0] == 2'h0);
		mapped  = mbSpace || (paddr[1:0] == 2'h0 &&
		          ((regIdx >= cmfr_pkg::IDX_DIR_EN &&
		            regIdx <= cmfr_pkg::IDX_STATUS) ||
		           (regIdx >= cmfr_pkg::IDX_MASK0_H &&
		            regIdx <= cmfr_pkg::IDX_MASK1_L)));
		apbWrite = psel && penable && pwrite;
		pready   = 1'b1; // zero wait states
		pslverr  = psel && penable && !mapped;
	end

	// ----------------------------------------------------------------
	// acceptance filter
	// ----------------------------------------------------------------
	always_comb begin
		eligible = 4'h0;
		hitFound = 1'b0;
		hitIdx   = 2'h0;
		// second mask pair serves 2,3 and first serves 0,1
		for (int m = 0; m < 4; m++) begin
			eligible[m] = rxValid && mailboxEnableBits[m] &&
			    (rxFrame.rtr || isRx(3'(m), mailboxDirectionBits)) &&
			    idMatch(mem[m][cmfr_pkg::WORD_ID_HIGH],
			            mem[m][cmfr_pkg::WORD_ID_LOW],
			            localMaskHigh[m / 2], localMaskLow[m / 2],
			            rxFrame);
		end
		// descending search, first hit stops it; 4,5 never looked at
		for (int m = 3; m >= 0; m--) begin
			if (!hitFound && eligible[m]) begin
				hitFound = 1'b1;
				hitIdx   = 2'(m);
			end
		end
		hitTx   = hitFound && !isRx({1'b0, hitIdx}, mailboxDirectionBits);
		storeEn = hitFound && !hitTx;
	end

	// ----------------------------------------------------------------
	// transmit candidate, highest first
	// ----------------------------------------------------------------
	always_comb begin
		candFound = 1'b0;
		candIdx   = 3'h0;
		for (int m = 5; m >= 2; m--) begin
			if (!candFound && transmitRequestFlag[m] && !transmitCancelFlag[m]
			    && mailboxEnableBits[m] &&
			    !(changeDataRequest &&
			      {1'b0, mailboxSelectField} == 3'(m))) begin
				candFound = 1'b1;
				candIdx   = 3'(m);
			end
		end
	end

	// ----------------------------------------------------------------
	// next values of registers, storage and transmit engine
	// ----------------------------------------------------------------
	always_comb begin
		next_mem                     = mem;
		next_mailboxDirectionEnable  = mailboxDirectionEnable;
		next_localMaskHigh           = localMaskHigh;
		next_localMaskLow            = localMaskLow;
		next_transmitRequestFlag     = transmitRequestFlag;
		next_transmitCancelFlag      = transmitCancelFlag;
		next_transmitAcknowledgeFlag = transmitAcknowledgeFlag;
		next_receivePendingFlag      = receivePendingFlag;
		next_changeDataRequest       = changeDataRequest;
		next_mailboxSelectField      = mailboxSelectField;
		next_writeDeniedFlag         = writeDeniedFlag;
		next_txState                 = txState;
		next_txMailbox               = txMailbox;
		next_txFrame                 = txFrame;
		next_prdata                  = prdata;
		// busy transmit mailbox locks data and control unless change-data
		denyData = mbSpace && cpuWord >= cmfr_pkg::WORD_CTRL &&
		    cpuMb >= 3'h2 && mailboxEnableBits[cpuMb] &&
		    !isRx(cpuMb, mailboxDirectionBits) &&
		    (transmitRequestFlag[cpuMb] || transmitCancelFlag[cpuMb]) &&
		    !(changeDataRequest && {1'b0, mailboxSelectField} == cpuMb);

		// acknowledge clears go first, so a completion in the same cycle
		// still leaves its acknowledge set
		if (apbWrite && regIdx == cmfr_pkg::IDX_TX_CTL) begin
			next_transmitAcknowledgeFlag =
			    transmitAcknowledgeFlag & ~pwdata[15:12];
		end

		// transmit engine; hardware clears first so cpu sets win
		case (txState)
			cmfr_pkg::TX_IDLE: begin
				// cancel requests that are not on the wire
				for (int m = 2; m < 6; m++) begin
					if (transmitCancelFlag[m]) begin
						next_transmitRequestFlag[m] = 1'b0;
						next_transmitCancelFlag[m]  = 1'b0;
					end
				end
				if (candFound) begin
					next_txState       = cmfr_pkg::TX_BUSY;
					next_txMailbox     = candIdx;
					next_txFrame.id    = {mem[candIdx][1][12:0], mem[candIdx][0]};
					next_txFrame.ide   = mem[candIdx][1][cmfr_pkg::IDH_IDE_BIT];
					next_txFrame.rtr   = isRx(candIdx, mailboxDirectionBits);
					next_txFrame.dlc   = mem[candIdx][2][3:0];
					next_txFrame.data  = {mem[candIdx][3], mem[candIdx][4],
					                      mem[candIdx][5], mem[candIdx][6]};
				end
			end
			cmfr_pkg::TX_BUSY: begin
				if (txDone) begin
					next_txState = cmfr_pkg::TX_IDLE;
					next_transmitRequestFlag[txMailbox] = 1'b0;
					next_transmitCancelFlag[txMailbox]  = 1'b0;
					if (!txFrame.rtr) begin
						next_transmitAcknowledgeFlag[txMailbox] = 1'b1;
					end
				end else if (txFail) begin
					// retried from idle unless cancel was asked for
					next_txState = cmfr_pkg::TX_IDLE;
				end
			end
			default: next_txState = cmfr_pkg::TX_IDLE;
		endcase

		// cpu register writes
		if (apbWrite) begin
			if (mbSpace) begin
				if (cpuWord == cmfr_pkg::WORD_ID_LOW ||
				    cpuWord == cmfr_pkg::WORD_ID_HIGH) begin
					if (!mailboxEnableBits[cpuMb]) begin
						next_mem[cpuMb][cpuWord] = pwdata[15:0];
					end
				end else if (denyData) begin
					next_writeDeniedFlag = 1'b1;
				end else begin
					next_mem[cpuMb][cpuWord] = pwdata[15:0];
				end
			end
			case (regIdx)
				cmfr_pkg::IDX_DIR_EN: next_mailboxDirectionEnable =
				    pwdata[15:0] & cmfr_pkg::DIR_EN_WMASK;
				cmfr_pkg::IDX_TX_CTL: begin
					next_transmitRequestFlag =
					    next_transmitRequestFlag | pwdata[7:4];
					next_transmitCancelFlag =
					    next_transmitCancelFlag | pwdata[3:0];
				end
				cmfr_pkg::IDX_RX_CTL: next_receivePendingFlag =
				    receivePendingFlag & ~pwdata[7:4];
				cmfr_pkg::IDX_MASTER: begin
					next_changeDataRequest  = pwdata[cmfr_pkg::CDR_BIT];
					next_mailboxSelectField = pwdata[1:0];
				end
				cmfr_pkg::IDX_STATUS: next_writeDeniedFlag =
				    next_writeDeniedFlag & ~pwdata[0];
				cmfr_pkg::IDX_MASK0_H: next_localMaskHigh[0] =
				    pwdata[15:0] & cmfr_pkg::MASK_H_WMASK;
				cmfr_pkg::IDX_MASK0_L: next_localMaskLow[0] = pwdata[15:0];
				cmfr_pkg::IDX_MASK1_H: next_localMaskHigh[1] =
				    pwdata[15:0] & cmfr_pkg::MASK_H_WMASK;
				cmfr_pkg::IDX_MASK1_L: next_localMaskLow[1] = pwdata[15:0];
				default: ;
			endcase
		end

		// reception; hardware sets win over cpu clears
		if (storeEn) begin
			next_mem[hitIdx][cmfr_pkg::WORD_ID_LOW] = rxFrame.id[15:0];
			next_mem[hitIdx][cmfr_pkg::WORD_ID_HIGH][12:0] = rxFrame.id[28:16];
			next_mem[hitIdx][cmfr_pkg::WORD_CTRL] =
			    {11'h000, rxFrame.rtr, rxFrame.dlc};
			for (int w = 0; w < 4; w++) begin
				next_mem[hitIdx][3 + w] = rxFrame.data[63 - 16 * w -: 16];
			end
			next_receivePendingFlag[hitIdx] = 1'b1;
		end else if (hitTx && mem[hitIdx][1][cmfr_pkg::IDH_AAM_BIT]) begin
			next_transmitRequestFlag[hitIdx] = 1'b1;
		end

		// read data captured in the setup phase
		if (psel && !penable) begin
			next_prdata = 32'h00000000;
			if (mbSpace) begin
				next_prdata[15:0] = mem[cpuMb][cpuWord];
			end
			case (regIdx)
				cmfr_pkg::IDX_DIR_EN:  next_prdata[15:0] = mailboxDirectionEnable;
				cmfr_pkg::IDX_TX_CTL:  next_prdata[15:0] =
				    {transmitAcknowledgeFlag, 4'h0, transmitRequestFlag,
				     transmitCancelFlag};
				cmfr_pkg::IDX_RX_CTL:  next_prdata[15:0] =
				    {8'h00, receivePendingFlag, 4'h0};
				cmfr_pkg::IDX_MASTER:  next_prdata[15:0] =
				    {7'h00, changeDataRequest, 6'h00, mailboxSelectField};
				cmfr_pkg::IDX_STATUS:  next_prdata[0] = writeDeniedFlag;
				cmfr_pkg::IDX_MASK0_H: next_prdata[15:0] = localMaskHigh[0];
				cmfr_pkg::IDX_MASK0_L: next_prdata[15:0] = localMaskLow[0];
				cmfr_pkg::IDX_MASK1_H: next_prdata[15:0] = localMaskHigh[1];
				cmfr_pkg::IDX_MASK1_L: next_prdata[15:0] = localMaskLow[1];
				default: ;
			endcase
		end
	end

	assign txReq = (txState == cmfr_pkg::TX_BUSY);

	// ----------------------------------------------------------------
	// registers; everything clears at reset
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int m = 0; m < cmfr_pkg::NUM_MB; m++) begin
				for (int w = 0; w < cmfr_pkg::MB_WORDS; w++) begin
					mem[m][w] <= cmfr_pkg::RST_WORD;
				end
			end
			mailboxDirectionEnable  <= cmfr_pkg::RST_WORD;
			localMaskHigh[0]        <= cmfr_pkg::RST_WORD;
			localMaskHigh[1]        <= cmfr_pkg::RST_WORD;
			localMaskLow[0]         <= cmfr_pkg::RST_WORD;
			localMaskLow[1]         <= cmfr_pkg::RST_WORD;
			transmitRequestFlag     <= 4'h0;
			transmitCancelFlag      <= 4'h0;
			transmitAcknowledgeFlag <= 4'h0;
			receivePendingFlag      <= 4'h0;
			changeDataRequest       <= 1'b0;
			mailboxSelectField      <= 2'h0;
			writeDeniedFlag         <= 1'b0;
			txState                 <= cmfr_pkg::TX_IDLE;
			txMailbox               <= 3'h0;
			txFrame                 <= '0;
			prdata                  <= 32'h00000000;
		end else begin
			mem                     <= next_mem;
			mailboxDirectionEnable  <= next_mailboxDirectionEnable;
			localMaskHigh           <= next_localMaskHigh;
			localMaskLow            <= next_localMaskLow;
			transmitRequestFlag     <= next_transmitRequestFlag;
			transmitCancelFlag      <= next_transmitCancelFlag;
			transmitAcknowledgeFlag <= next_transmitAcknowledgeFlag;
			receivePendingFlag      <= next_receivePendingFlag;
			changeDataRequest       <= next_changeDataRequest;
			mailboxSelectField      <= next_mailboxSelectField;
			writeDeniedFlag         <= next_writeDeniedFlag;
			txState                 <= next_txState;
			txMailbox               <= next_txMailbox;
			txFrame                 <= next_txFrame;
			prdata                  <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	AST_NO_REMOTE_HIGH: assert property (
		txReq && txMailbox >= 3'h4 |-> !txFrame.rtr)
		else $error("mailbox 4 or 5 sent a remote frame");
	AST_AUTO_ANSWER: assert property (
		hitTx && mem[hitIdx][1][cmfr_pkg::IDH_AAM_BIT]
		|=> transmitRequestFlag[{1'b0, $past(hitIdx)}])
		else $error("auto-answer did not raise transmit request");
	AST_TX_HIT_NOT_STORED: assert property (
		hitTx && !(apbWrite && regIdx == cmfr_pkg::IDX_RX_CTL)
		|=> receivePendingFlag[$past(hitIdx)]
		    == $past(receivePendingFlag[hitIdx]))
		else $error("remote hit on transmit mailbox was stored");
	AST_STORE_PENDING: assert property (
		storeEn |=> receivePendingFlag[$past(hitIdx)] &&
		    mem[$past(hitIdx)][0] == $past(rxFrame.id[15:0]))
		else $error("receive hit not stored or pending not set");
	AST_CDR_WITHHOLD: assert property (
		txState == cmfr_pkg::TX_IDLE && changeDataRequest
		|=> !(txReq && $rose(txReq) &&
		      txMailbox == {1'b0, $past(mailboxSelectField)}))
		else $error("selected mailbox sent during change-data");
	AST_REMOTE_NO_ACK: assert property (
		txReq && txDone && txFrame.rtr
		|=> !transmitRequestFlag[$past(txMailbox)] &&
		    (transmitAcknowledgeFlag & ~$past(transmitAcknowledgeFlag)) == 0)
		else $error("remote send left request or set acknowledge");
	AST_ORDER: assert property (
		storeEn && hitIdx < 2'h2 |-> eligible[3:2] == 2'h0)
		else $error("lower mailbox taken over a higher hit");
	AST_ID_LOCK: assert property (
		apbWrite && mbSpace && cpuWord == cmfr_pkg::WORD_ID_LOW &&
		mailboxEnableBits[cpuMb] && !storeEn
		|=> mem[$past(cpuMb)][0] == $past(mem[cpuMb][0]))
		else $error("identifier changed while mailbox enabled");
	AST_DENY_FLAG: assert property (
		apbWrite && denyData |=> writeDeniedFlag &&
		    mem[$past(cpuMb)][$past(cpuWord)] == $past(mem[cpuMb][cpuWord]))
		else $error("denied write not flagged");

	COV_AUTO_ANSWER: cover property (hitTx ##1 txReq);
	COV_REMOTE_SEND: cover property (txReq && txFrame.rtr && txDone);
	COV_STORE_HIGH:  cover property (storeEn && hitIdx == 2'h3);
	COV_DENIED:      cover property (apbWrite && denyData);

endmodule

/* File: rtl/cmfr_pkg.sv */
package cmfr_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int NUM_MB    = 6;
	localparam int MB_WORDS  = 7;
	localparam int ADDR_W    = 18;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_DIR_EN  = 16'h7100;
	localparam logic [15:0] IDX_TX_CTL  = 16'h7101;
	localparam logic [15:0] IDX_RX_CTL  = 16'h7102;
	localparam logic [15:0] IDX_MASTER  = 16'h7103;
	localparam logic [15:0] IDX_STATUS  = 16'h7104;
	localparam logic [15:0] IDX_MASK0_H = 16'h7110;
	localparam logic [15:0] IDX_MASK0_L = 16'h7111;
	localparam logic [15:0] IDX_MASK1_H = 16'h7112;
	localparam logic [15:0] IDX_MASK1_L = 16'h7113;
	localparam logic [15:0] IDX_MB_BASE = 16'h7200;

	// mailbox word order inside an eight-index slot
	localparam logic [2:0] WORD_ID_LOW  = 3'h0;
	localparam logic [2:0] WORD_ID_HIGH = 3'h1;
	localparam logic [2:0] WORD_CTRL    = 3'h2;
	localparam logic [2:0] WORD_DATA0   = 3'h3;

	// ----------------------------------------------------------------
	// field positions and writable masks
	// ----------------------------------------------------------------
	localparam int IDH_IDE_BIT   = 15;
	localparam int IDH_AME_BIT   = 14;
	localparam int IDH_AAM_BIT   = 13;
	localparam int MASK_EXT_BIT  = 15;
	localparam int DIR_LSB       = 6;
	localparam int CDR_BIT       = 8;
	localparam logic [15:0] DIR_EN_WMASK = 16'h00ff;
	localparam logic [15:0] MASK_H_WMASK = 16'h9fff;
	localparam logic [28:0] STD_ID_BITS  = 29'h1ffc0000;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_WORD = 16'h0000;

	typedef struct packed {
		logic [28:0] id;
		logic        ide;
		logic        rtr;
		logic [3:0]  dlc;
		logic [63:0] data;
	} cmfr_frame_type;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_BUSY = 1'b1
	} cmfr_tx_state_type;

endpackage

/* File: tb/cmfr_engine_model.sv */
module cmfr_engine_model (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	// offer from the block
	input  wire logic                     txReq,
	input  wire logic [2:0]               txMailbox,
	input  wire cmfr_pkg::cmfr_frame_type txFrame,
	output logic                          txDone,
	output logic                          txFail,
	// bench view
	input  wire logic                     slow,
	output logic      [7:0]               sentCount,
	output logic      [3:0]               lastSent
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [4:0] waitCnt;
	logic       failedOnce;

	// a slow node holds the offer longer, as a busy bus would; its first
	// offer is lost once, as in lost arbitration, so the retry path runs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			txDone     <= 1'b0;
			txFail     <= 1'b0;
			failedOnce <= 1'b0;
			waitCnt    <= 5'h00;
			sentCount  <= 8'h00;
			lastSent   <= 4'h0;
		end else begin
			txDone <= 1'b0;
			txFail <= 1'b0;
			if (txReq && !txDone && !txFail) begin
				waitCnt <= waitCnt + 5'h01;
				if (waitCnt >= (slow ? 5'h14 : 5'h02)) begin
					waitCnt <= 5'h00;
					if (slow && !failedOnce) begin
						txFail     <= 1'b1;
						failedOnce <= 1'b1;
					end else begin
						txDone    <= 1'b1;
						sentCount <= sentCount + 8'h01;
						lastSent  <= {txFrame.rtr, txMailbox};
					end
				end
			end
		end
	end
endmodule

/* File: tb/cmfr_mailbox_filter_tb.sv */
module cmfr_mailbox_filter_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                     sys_clk = 1'b0;
	logic                     reset_n = 1'b0;
	logic                     psel = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite = 1'b0;
	logic [17:0]              paddr = 18'h00000;
	logic [31:0]              pwdata = 32'h00000000;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr, errVal;
	logic                     rxValid = 1'b0;
	cmfr_pkg::cmfr_frame_type rxFrame = '0;
	logic                     txReq, txDone, txFail, slow = 1'b0;
	logic [2:0]               txMailbox;
	cmfr_pkg::cmfr_frame_type txFrame;
	logic [7:0]               sentCount, c0;
	logic [3:0]               lastSent;
	logic [31:0]              rdVal;
	int                       miscompares = 0;
	int                       cmp_count = 0;

	always #12.5 sys_clk = ~sys_clk;

	cmfr_mailbox_filter dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxValid(rxValid), .rxFrame(rxFrame), .txReq(txReq),
		.txMailbox(txMailbox), .txFrame(txFrame), .txDone(txDone),
		.txFail(txFail));

	cmfr_engine_model far (.sys_clk(sys_clk), .reset_n(reset_n),
		.txReq(txReq), .txMailbox(txMailbox), .txFrame(txFrame),
		.txDone(txDone), .txFail(txFail), .slow(slow),
		.sentCount(sentCount), .lastSent(lastSent));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	// one apb transfer; held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [15:0] idx,
			input logic [15:0] wd);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		rdVal = prdata;
		errVal = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) begin
			miscompares++;
			print_verdict();
		end
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 16'h0000);
		chk(rdVal, exp);
	endtask

	function automatic logic [15:0] mbi(input logic [2:0] mb,
			input logic [2:0] w);
		return cmfr_pkg::IDX_MB_BASE + {10'h000, mb, w};
	endfunction

	// one extended frame from another node
	task automatic rx(input logic [28:0] id, input logic rtr);
		@(posedge sys_clk);
		rxValid <= 1'b1;
		rxFrame <= {id, 1'b1, rtr, 4'h8, 64'hbeef_0000_0000_0001};
		@(posedge sys_clk);
		rxValid <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic waitTx();
		int n;
		for (n = 0; n < 100 && sentCount === c0; n++) @(posedge sys_clk);
		if (n == 100) begin
			miscompares++;
			print_verdict();
		end
		repeat (3) @(posedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(cmfr_pkg::IDX_DIR_EN, 32'h0);
		chk({31'h0, errVal}, 32'h0);
		rd(16'h7105, 32'h0);
		chk({31'h0, errVal}, 32'h1);
		apb(1'b1, cmfr_pkg::IDX_MASK0_H, 16'hffff);
		rd(cmfr_pkg::IDX_MASK0_H, 32'h9fff);
		apb(1'b1, cmfr_pkg::IDX_MASK0_H, 16'h0000);
		apb(1'b1, cmfr_pkg::IDX_DIR_EN, 16'hff00);
		rd(cmfr_pkg::IDX_DIR_EN, 32'h0);
		// identifiers written while disabled
		apb(1'b1, mbi(0, 1), 16'h8123);
		apb(1'b1, mbi(0, 0), 16'h4667);
		apb(1'b1, mbi(2, 1), 16'hc123);
		apb(1'b1, mbi(2, 0), 16'h4500);
		apb(1'b1, mbi(3, 1), 16'ha123);
		apb(1'b1, mbi(3, 0), 16'h7777);
		apb(1'b1, mbi(4, 1), 16'h8000);
		apb(1'b1, cmfr_pkg::IDX_MASK1_L, 16'h00ff);
		apb(1'b1, cmfr_pkg::IDX_DIR_EN, 16'h005d);
		apb(1'b1, mbi(0, 1), 16'h0000);
		rd(mbi(0, 1), 32'h8123);
		rx(29'h01234567, 1'b0); // hits mb2 masked and mb0 not
		rd(cmfr_pkg::IDX_RX_CTL, 32'h0040);
		rd(mbi(2, 3), 32'hbeef);
		apb(1'b1, cmfr_pkg::IDX_RX_CTL, 16'h0040);
		rx(29'h01234667, 1'b0);
		rx(29'h01234668, 1'b0);
		rd(cmfr_pkg::IDX_RX_CTL, 32'h0010);
		apb(1'b1, cmfr_pkg::IDX_RX_CTL, 16'h0010);
		c0 = sentCount;
		rx(29'h01237777, 1'b1);
		waitTx();
		chk({28'h0, lastSent}, 32'h3);
		rd(cmfr_pkg::IDX_TX_CTL, 32'h2000);
		rd(cmfr_pkg::IDX_RX_CTL, 32'h0);
		c0 = sentCount;
		rx(29'h0, 1'b1);
		repeat (10) @(posedge sys_clk);
		chk({24'h0, sentCount}, {24'h0, c0});
		apb(1'b1, cmfr_pkg::IDX_TX_CTL, 16'h0010);
		waitTx();
		chk({28'h0, lastSent}, 32'ha);
		rd(cmfr_pkg::IDX_TX_CTL, 32'h2000);
		slow <= 1'b1;
		c0 = sentCount;
		apb(1'b1, cmfr_pkg::IDX_TX_CTL, 16'h0040);
		apb(1'b1, mbi(4, 3), 16'habcd);
		rd(cmfr_pkg::IDX_STATUS, 32'h1);
		rd(mbi(4, 3), 32'h0);
		waitTx();
		chk({28'h0, lastSent}, 32'h4);
		rd(cmfr_pkg::IDX_TX_CTL, 32'h6000);
		// change-data on mailbox 3 holds back its auto-answer
		slow <= 1'b0;
		c0 = sentCount;
		apb(1'b1, cmfr_pkg::IDX_MASTER, 16'h0103);
		rx(29'h01237777, 1'b1);
		apb(1'b1, mbi(3, 3), 16'h1234);
		repeat (10) @(posedge sys_clk);
		chk({24'h0, sentCount}, {24'h0, c0});
		rd(mbi(3, 3), 32'h1234);
		apb(1'b1, cmfr_pkg::IDX_MASTER, 16'h0000);
		waitTx();
		chk({28'h0, lastSent}, 32'h3);
		print_verdict();
	end
endmodule
